// *** verilog/mpwc_top.sv ***
module mpwc_top
	import mpwc_pkg::*;
#(
	parameter int unsigned WAKE_CYCLES   = WAKE_CYC,
	parameter int unsigned DETACH_CYCLES = DETACH_CYC,
	parameter int unsigned KEY_OFF_CYCLES = KEY_OFF_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic wake_key_n,
	input  wire logic fast_gpio,
	input  wire logic fast_shutdown_command,
	input  wire logic shutdown_command,
	input  wire logic system_halt_command,
	input  wire logic psm_enable,
	input  wire logic psm_timer_expired,
	input  wire logic psm_wake_due,
	input  wire logic unconditional_req,
	output logic      power_on_indicator,
	output logic      baseband_on,
	output logic      detach_active,
	output logic      module_reset
);

	initial begin
		if (WAKE_CYCLES < 1 || DETACH_CYCLES < 1 || KEY_OFF_CYCLES < 1)
			$error("mpwc_top: timing counts must be at least one");
		if (DETACH_CYCLES >= (64'h1 << CNT_W))
			$error("mpwc_top: detach count too wide for counter");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		mpwc_state_t      st;
		logic             gs1;
		logic             gs2;
		logic             gs3;
		logic             armed;
		logic [CNT_W-1:0] dcnt;
		logic             ind;
		logic             bb;
		logic             det;
		logic             rst;
	} mpwc_reg_t;

	mpwc_reg_t r;
	mpwc_reg_t next_r;

	logic wake_done;
	logic off_done;
	logic key_low;
	logic fast_edge;

	assign key_low   = !wake_key_n;
	assign fast_edge = r.gs3 && !r.gs2;

	// ****************************************
	// Key hold timers
	// ****************************************
	mpwc_hold_timer #(
		.LIMIT (WAKE_CYCLES)
	) u_wake (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (key_low && (r.st == MPWC_OFF
			|| (r.st == MPWC_PSM && r.armed))),
		.done  (wake_done)
	);

	mpwc_hold_timer #(
		.LIMIT (KEY_OFF_CYCLES)
	) u_keyoff (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (key_low && r.st == MPWC_ON),
		.done  (off_done)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		next_r = r;
		next_r.gs1 = fast_gpio;
		next_r.gs2 = r.gs1;
		next_r.gs3 = r.gs2;
		next_r.dcnt = '0;
		next_r.armed = (r.st == MPWC_PSM)
			&& (r.armed || !key_low);
		case (r.st)
			MPWC_OFF: begin
				if (wake_done)
					next_r.st = MPWC_ON;
			end
			MPWC_ON: begin
				if (unconditional_req || system_halt_command)
					next_r.st = MPWC_HALT;
				else if (fast_edge || fast_shutdown_command)
					next_r.st = MPWC_FAST;
				else if (shutdown_command || off_done)
					next_r.st = MPWC_DETACH;
				else if (psm_enable && psm_timer_expired)
					next_r.st = MPWC_PSM;
			end
			MPWC_DETACH: begin
				next_r.dcnt = r.dcnt + CNT_W'(1);
				if (r.dcnt >= CNT_W'(DETACH_CYCLES - 1))
					next_r.st = MPWC_OFF;
			end
			MPWC_FAST: begin
				next_r.st = MPWC_OFF;
			end
			MPWC_PSM: begin
				if (wake_done || psm_wake_due)
					next_r.st = MPWC_ON;
			end
			MPWC_HALT: begin
				if (!unconditional_req)
					next_r.st = MPWC_OFF;
			end
			default: next_r.st = MPWC_OFF;
		endcase
		next_r.ind = (next_r.st != MPWC_OFF) && (next_r.st != MPWC_PSM)
			&& (next_r.st != MPWC_HALT);
		next_r.bb  = next_r.ind;
		next_r.det = (next_r.st == MPWC_DETACH);
		next_r.rst = (next_r.st == MPWC_HALT);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r    <= '0;
			r.st <= MPWC_OFF;
		end else begin
			r <= next_r;
		end
	end

	assign power_on_indicator = r.ind;
	assign baseband_on        = r.bb;
	assign detach_active      = r.det;
	assign module_reset       = r.rst;

	// ****************************************
	// Checks
	// ****************************************
	AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_PSM && wake_done && !psm_wake_due)
		|=> r.st == MPWC_ON)
		else $error("key wake ignored");
	AST_PSM: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_ON && psm_enable && psm_timer_expired
		&& !unconditional_req && !system_halt_command && !fast_edge
		&& !fast_shutdown_command && !shutdown_command && !off_done)
		|=> r.st == MPWC_PSM && !power_on_indicator)
		else $error("no power saving entry");
	AST_FASTGPIO: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_ON && fast_edge && !unconditional_req
		&& !system_halt_command) |=> r.st == MPWC_FAST ##1 r.st == MPWC_OFF)
		else $error("gpio fast shutdown missed");
	AST_FASTCMD: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_ON && fast_shutdown_command && !unconditional_req
		&& !system_halt_command) |=> r.st == MPWC_FAST)
		else $error("fast command missed");
	AST_DETACH: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(r.st == MPWC_DETACH) |-> (r.st == MPWC_DETACH)[*8])
		else $error("detach ended early");
	AST_SHDN: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_ON && shutdown_command && !unconditional_req
		&& !system_halt_command && !fast_edge && !fast_shutdown_command)
		|=> ##1 detach_active)
		else $error("shutdown command ignored");
	AST_HALT: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_HALT) |-> (module_reset && !power_on_indicator))
		else $error("halt not in reset");
	AST_IND: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_ON) |=> power_on_indicator || r.st != MPWC_ON)
		else $error("indicator low while on");
	AST_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_OFF) |=> (r.st == MPWC_OFF || r.st == MPWC_ON))
		else $error("illegal exit from off");
	AST_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
		fast_edge |-> $past(fast_gpio, 3) && !$past(fast_gpio, 2)
		&& !$past(fast_edge))
		else $error("edge request without a pin fall");

	// ****************************************
	// Output and hold checks
	// ****************************************
	AST_TIED: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_PSM && !r.armed && !psm_wake_due)
		|=> r.st == MPWC_PSM)
		else $error("unarmed key woke module");
	AST_KEYOFF: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_ON && off_done && !unconditional_req
		&& !system_halt_command && !fast_edge && !fast_shutdown_command)
		|=> detach_active)
		else $error("key power-off ignored");
	AST_LOWIND: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_PSM || r.st == MPWC_OFF)
		|-> !power_on_indicator && !baseband_on)
		else $error("indicator high while off");
	AST_PSMLINE: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_PSM && unconditional_req && !wake_done
		&& !psm_wake_due) |=> r.st == MPWC_PSM && !module_reset)
		else $error("line shutdown acted in saving");
	AST_HALTHOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_HALT && unconditional_req) |=> r.st == MPWC_HALT)
		else $error("halt left while line held");
	AST_HALTOFF: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_HALT && !unconditional_req)
		|=> r.st == MPWC_OFF && !detach_active)
		else $error("halt release not off");
	AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_PSM && !key_low) |=> !wake_done)
		else $error("wake timer kept count");
	AST_FASTOFF: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_FAST) |=> r.st == MPWC_OFF && !power_on_indicator)
		else $error("fast power-down not off");
	AST_DETOUT: assert property (@(posedge clk) disable iff (!rst_n)
		(r.st == MPWC_DETACH) |-> detach_active && power_on_indicator)
		else $error("detach outputs wrong");

endmodule

// *** include/mpwc_pkg.sv ***
package mpwc_pkg;

	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned WAKE_HOLD_S   = 5;
	localparam int unsigned DETACH_MIN_MS = 1000;
	localparam int unsigned KEY_OFF_MS    = 3000;
	localparam int unsigned WAKE_CYC      = WAKE_HOLD_S * CLK_HZ;
	localparam int unsigned DETACH_CYC    = (DETACH_MIN_MS / 1000) * CLK_HZ + 1;
	localparam int unsigned KEY_OFF_CYC   = (KEY_OFF_MS / 1000) * CLK_HZ;
	localparam int unsigned CNT_W         = 28;

	typedef enum logic [2:0] {
		MPWC_OFF,
		MPWC_ON,
		MPWC_DETACH,
		MPWC_FAST,
		MPWC_PSM,
		MPWC_HALT
	} mpwc_state_t;

endpackage

// *** verilog/mpwc_hold_timer.sv ***
module mpwc_hold_timer
	import mpwc_pkg::*;
#(
	parameter int unsigned LIMIT = 5
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      done
);

	initial begin
		if (LIMIT < 1 || LIMIT >= (64'h1 << CNT_W))
			$error("mpwc_hold_timer: LIMIT out of range");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             done;
	} mpwc_tmr_t;

	mpwc_tmr_t r;
	mpwc_tmr_t next_r;

	// Counts while run is high, restarts when run drops
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		if (!run) begin
			next_r.cnt = '0;
		end else if (r.cnt < CNT_W'(LIMIT - 1)) begin
			next_r.cnt = r.cnt + CNT_W'(1);
		end else begin
			next_r.done = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

	assign done = r.done;

endmodule

// *** tb/mpwc_host_model.sv ***
// ****
// Host side: wake key and fast-shutdown pin
// ****
module mpwc_host_model (
	input  wire logic clk,
	output logic      wake_key_n,
	output logic      fast_gpio
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle levels; supply is never cut here
	initial begin
		wake_key_n = 1'b1;
		fast_gpio  = 1'b1;
	end

	// Key left at one level until changed again
	task automatic key_level(input logic v);
		@(negedge clk) wake_key_n = v;
	endtask

	// Key held low for n cycles, then released
	task automatic key_hold(input int n);
		@(negedge clk) wake_key_n = 1'b0;
		repeat (n) @(negedge clk);
		wake_key_n = 1'b1;
	endtask

	// One high-to-low step on the pin, high again later
	task automatic gpio_fall();
		@(negedge clk) fast_gpio = 1'b0;
		repeat (6) @(negedge clk);
		fast_gpio = 1'b1;
	endtask
endmodule

// *** tb/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int DET_CYC = 10;
	localparam int P_SD    = 0;
	localparam int P_FC    = 1;
	localparam int P_DUE   = 2;
	localparam int P_EXP   = 3;
	localparam int P_HALT  = 4;

	logic clk, rst_n, fcmd, sdcmd, halt, psm_en, psm_exp, psm_due, uncond;
	logic ind, bb, det, mrst;
	wire logic key_n, gpio;
	int   n_errors = 0;
	int   num_checks = 0;
	int   det_cnt = 0;
	int   det_base = 0;

	mpwc_top #(.WAKE_CYCLES(8), .DETACH_CYCLES(DET_CYC),
		.KEY_OFF_CYCLES(12))
	mpwc_top_i (.clk(clk), .rst_n(rst_n), .wake_key_n(key_n),
		.fast_gpio(gpio), .fast_shutdown_command(fcmd),
		.shutdown_command(sdcmd), .system_halt_command(halt),
		.psm_enable(psm_en), .psm_timer_expired(psm_exp),
		.psm_wake_due(psm_due), .unconditional_req(uncond),
		.power_on_indicator(ind), .baseband_on(bb),
		.detach_active(det), .module_reset(mrst));
	mpwc_host_model mpwc_host_model_i (.clk(clk), .wake_key_n(key_n),
		.fast_gpio(gpio));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (det === 1'b1) det_cnt <= det_cnt + 1;

	// ****
	// Helpers
	// ****
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp, input string s);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t %s", $time, s);
		end
	endtask
	task automatic wait_ind(input logic exp, input int lim);
		for (int i = 0; i < lim && ind !== exp; i++) @(negedge clk);
		chk(ind, exp, "indicator");
	endtask
	task automatic drive_cmd(input int sel, input logic v);
		case (sel)
			P_SD:    sdcmd   = v;
			P_FC:    fcmd    = v;
			P_DUE:   psm_due = v;
			P_EXP:   psm_exp = v;
			default: halt    = v;
		endcase
	endtask
	task automatic pulse(input int sel);
		@(negedge clk) drive_cmd(sel, 1'b1);
		@(negedge clk) drive_cmd(sel, 1'b0);
	endtask
	task automatic wake();
		mpwc_host_model_i.key_hold(14);
		wait_ind(1'b1, 10);
		chk(bb, 1'b1, "baseband");
		det_base = det_cnt;
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_off_wake();
		int n;
		pulse(P_SD);
		pulse(P_FC);
		pulse(P_DUE);
		pulse(P_HALT);
		chk(ind, 1'b0, "off left");
		mpwc_host_model_i.key_hold(4);
		repeat (20) @(negedge clk);
		chk(ind, 1'b0, "short key");
		wake();
		pulse(P_SD);
		n = 1;
		chk(det, 1'b1, "detach");
		while (det === 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		chk(n == DET_CYC + 1, 1'b1, "detach length");
		chk(ind, 1'b0, "off after detach");
		wake();
		mpwc_host_model_i.key_hold(20);
		chk(det, 1'b1, "key off");
		wait_ind(1'b0, 30);
	endtask
	task automatic t_fast();
		wake();
		mpwc_host_model_i.gpio_fall();
		wait_ind(1'b0, 40);
		chk(det_cnt == det_base, 1'b1, "gpio detach");
		wake();
		pulse(P_FC);
		wait_ind(1'b0, 40);
		chk(det_cnt == det_base, 1'b1, "cmd detach");
	endtask
	task automatic t_psm_halt();
		wake();
		psm_en = 1'b1;
		pulse(P_EXP);
		chk(ind, 1'b0, "saving");
		@(negedge clk) uncond = 1'b1;
		repeat (3) @(negedge clk);
		chk(mrst, 1'b0, "line in saving");
		chk(ind, 1'b0, "still saving");
		uncond = 1'b0;
		wake();
		mpwc_host_model_i.key_level(1'b0);
		pulse(P_EXP);
		repeat (20) @(negedge clk);
		chk(ind, 1'b0, "tied key");
		mpwc_host_model_i.key_level(1'b1);
		pulse(P_DUE);
		chk(ind, 1'b1, "scheduled wake");
		psm_en = 1'b0;
		pulse(P_HALT);
		chk(mrst, 1'b1, "halt reset");
		chk(ind, 1'b0, "halt off");
		@(negedge clk);
		chk(mrst, 1'b0, "halt end");
		chk(ind, 1'b0, "off after halt");
		wake();
		@(negedge clk) uncond = 1'b1;
		repeat (3) @(negedge clk);
		chk(mrst, 1'b1, "line reset");
		chk(ind, 1'b0, "line off");
		uncond = 1'b0;
		repeat (2) @(negedge clk);
		chk(mrst, 1'b0, "halt release");
		chk(det_cnt == det_base, 1'b1, "halt detach");
	endtask

	initial begin
		{rst_n, fcmd, sdcmd, halt, psm_en, psm_exp, psm_due, uncond} = '0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_off_wake();
		t_fast();
		t_psm_halt();
		end_of_test();
	end
	initial begin
		#(40 * 5000);
		n_errors++;
		end_of_test();
	end
endmodule
